// >>> logic/imw_pkg.sv
package imw_pkg;

   // Timing: CPU-ready delay, internal oscillator stabilisation and oscillator start-up timer
   localparam int CLK_HZ = 40000000;
   localparam int CPU_READY_NS = 200;
   localparam int CPU_READY_CYC = (CPU_READY_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int OSC_STAB_NS = 1000;
   localparam int OSC_STAB_CYC = (OSC_STAB_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int OST_NS = 2000;
   localparam int OST_CYC = (OST_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int CNT_W = 16;

   // Register map (byte addresses)
   localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
   localparam logic [7:0] ADDR_IRQ_CTRL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_WDT = 8'h0C;

   // Oscillator control fields
   localparam int SCS_LSB = 0;
   localparam int IDLE_BIT = 7;
   localparam int INTERNAL_FREQ_SELECT_LSB = 4;
   localparam int SRC_BIT = 3;
   localparam int T1EN_BIT = 2;
   localparam int WDTEN_BIT = 8;
   localparam int FSCM_BIT = 9;
   localparam int TSS_BIT = 10;
   // Interrupt control fields
   localparam int GIE_BIT = 7;
   // Status fields
   localparam int ST_PRIMARY_CLK_READY_FLAG = 0;
   localparam int ST_INTERNAL_OSC_STABLE_FLAG = 1;
   localparam int ST_SECONDARY_OSC_RUNNING_FLAG = 2;
   localparam int ST_CPU = 3;
   localparam int ST_MODE_LSB = 4;
   // Watchdog register: write with this bit set clears the counter
   localparam int WDT_CLR_BIT = 0;

   localparam logic [31:0] OSC_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] IRQ_CTRL_RST = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int WDT_W = 16;

   typedef enum logic [5:0] {
      ST_RESET = 6'b000001,
      ST_RUN = 6'b000010,
      ST_IDLE = 6'b000100,
      ST_SLEEP = 6'b001000,
      ST_WAKE = 6'b010000,
      ST_WDT_RST = 6'b100000
   } imw_state_e;

endpackage

// >>> logic/imw_delay_cnt.sv
module imw_delay_cnt
   import imw_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic start,
   input wire logic abort,
   input wire logic [CNT_W-1:0] cycles,
   // Status
   output logic busy,
   output logic done
);

   logic [CNT_W-1:0] cnt_r;

   always_ff @(posedge aclk) begin
      if (!aresetn || abort) begin
         cnt_r <= '0;
         done <= 1'b0;
      end else if (start) begin
         cnt_r <= cycles;
         done <= 1'b0;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
         done <= (cnt_r == CNT_W'(1));
      end else begin
         done <= 1'b0;
      end
   end

   assign busy = (cnt_r != '0);

endmodule

// >>> logic/imw_wake_ctrl.sv
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
module imw_wake_ctrl
   import imw_pkg::*;
#(
   parameter logic [CNT_W-1:0] CPU_READY_CYCLES = CNT_W'(CPU_READY_CYC),
   parameter logic [CNT_W-1:0] OSC_STAB_CYCLES = CNT_W'(OSC_STAB_CYC),
   parameter logic [CNT_W-1:0] OST_CYCLES = CNT_W'(OST_CYC),
   parameter logic [WDT_W-1:0] WDT_PERIOD = 16'hFFFF
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Instruction decoder
   input wire logic sleep_instr,
   input wire logic watchdog_clear_instr,
   // Interrupt sources
   input wire logic [7:0] irq_flags,
   input wire logic [7:0] irq_enables,
   // Oscillators, clock loss and external reset request
   input wire logic primary_osc_ready,
   input wire logic clk_loss,
   input wire logic ext_reset_req,
   // Clock and core control
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic [1:0] periph_clk_src,
   output logic primary_osc_en,
   output logic secondary_osc_en,
   output logic internal_osc_out_en,
   output logic internal_slow_osc_en,
   output logic irq_vector_branch,
   output logic watchdog_reset,
   output logic cpu_start
);

   ////////////////////////////////////////////////////////////////////////////////
   // Register file

   logic [31:0] osc_ctrl_r;
   logic [31:0] irq_ctrl_r;
   logic primary_clk_ready_flag_r;
   logic internal_osc_stable_flag_r;
   logic secondary_osc_running_flag_r;
   imw_state_e state_r;
   logic [1:0] run_src_r;
   logic [WDT_W-1:0] wdt_cnt_r;

   logic [1:0] sys_clk_select;
   logic idle_on_sleep_sel;
   logic [2:0] internal_freq_select;
   logic internal_source_select;
   logic secondary_osc_enable;
   logic wdt_enable;
   logic clk_monitor_en;
   logic two_speed_en;
   logic global_irq_enable;

   assign sys_clk_select = osc_ctrl_r[SCS_LSB +: 2];
   assign idle_on_sleep_sel = osc_ctrl_r[IDLE_BIT];
   assign internal_freq_select = osc_ctrl_r[INTERNAL_FREQ_SELECT_LSB +: 3];
   assign internal_source_select = osc_ctrl_r[SRC_BIT];
   assign secondary_osc_enable = osc_ctrl_r[T1EN_BIT];
   assign wdt_enable = osc_ctrl_r[WDTEN_BIT];
   assign clk_monitor_en = osc_ctrl_r[FSCM_BIT];
   assign two_speed_en = osc_ctrl_r[TSS_BIT];
   assign global_irq_enable = irq_ctrl_r[GIE_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave

   logic aw_hold_r;
   logic w_hold_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_fire;
   logic osc_wr;
   logic wdt_wr;
   logic [31:0] osc_ctrl_nxt;

   assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
   assign wr_fire = aw_hold_r && w_hold_r;
   assign osc_wr = wr_fire && (awaddr_r == ADDR_OSC_CTRL);
   assign wdt_wr = wr_fire && (awaddr_r == ADDR_WDT) && wstrb_r[0] && wdata_r[WDT_CLR_BIT];

   always_comb begin
      osc_ctrl_nxt = osc_ctrl_r;
      for (int b = 0; b < 4; b++) begin
         if (wstrb_r[b]) begin
            osc_ctrl_nxt[b*8 +: 8] = wdata_r[b*8 +: 8];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_r == ADDR_OSC_CTRL || awaddr_r == ADDR_IRQ_CTRL ||
                            awaddr_r == ADDR_STATUS || awaddr_r == ADDR_WDT) ?
                           RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control registers; wake never touches them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_ctrl_r <= OSC_CTRL_RST;
         irq_ctrl_r <= IRQ_CTRL_RST;
      end else if (wr_fire) begin
         if (awaddr_r == ADDR_OSC_CTRL) begin
            osc_ctrl_r <= osc_ctrl_nxt;
         end
         if (awaddr_r == ADDR_IRQ_CTRL && wstrb_r[0]) begin
            irq_ctrl_r[7:0] <= wdata_r[7:0];
         end
      end
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         unique case (s_axi_araddr)
            ADDR_OSC_CTRL: s_axi_rdata <= osc_ctrl_r;
            ADDR_IRQ_CTRL: s_axi_rdata <= {24'h000000, irq_ctrl_r[7:0]};
            ADDR_STATUS: s_axi_rdata <= {27'h0000000, state_r == ST_WAKE,
               cpu_clk_en, secondary_osc_running_flag_r, internal_osc_stable_flag_r,
               primary_clk_ready_flag_r};
            ADDR_WDT: s_axi_rdata <= {16'h0000, wdt_cnt_r};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mode sequencer

   logic sleep_ok;
   logic irq_wake;
   logic wdt_timeout;
   logic wake_evt;
   logic rdy_start;
   logic rdy_busy;
   logic wake_go;
   logic stab_start;
   logic stab_busy;
   logic stab_done;
   logic ost_start;
   logic ost_busy;
   logic ost_done;
   logic irq_wake_r;
   logic internal_fast_osc_req;

   assign internal_fast_osc_req = (internal_freq_select != 3'h0) || internal_source_select;
   // the selected source picks the idle flavour; sleep is ignored on secondary while secondary_osc_enable is clear
   assign sleep_ok = sleep_instr && !(sys_clk_select == 2'b01 && !secondary_osc_enable);
   assign irq_wake = |(irq_flags & irq_enables);
   assign wdt_timeout = wdt_enable && (wdt_cnt_r == WDT_PERIOD);
   assign wake_evt = irq_wake || wdt_timeout;
   assign rdy_start = (state_r == ST_IDLE || state_r == ST_SLEEP) && wake_evt;
   // Both delays run side by side; leave only once neither is still counting
   assign wake_go = (state_r == ST_WAKE) && !rdy_busy && !ost_busy;
   assign stab_start = internal_fast_osc_req && !internal_osc_stable_flag_r && !stab_busy &&
                       (sys_clk_select[1] || state_r == ST_RESET);
   assign ost_start = (state_r == ST_SLEEP && wake_evt && run_src_r == 2'b00) ||
                      (state_r == ST_RESET && !ost_busy && !ost_done && primary_osc_ready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_RESET;
         run_src_r <= 2'b00;
         irq_wake_r <= 1'b0;
      end else begin
         unique case (state_r)
            ST_RESET: begin
               if (ext_reset_req) begin
                  state_r <= ST_RESET;
               end else if (ost_done || two_speed_en || clk_monitor_en) begin
                  state_r <= ST_RUN;
                  run_src_r <= (ost_done || primary_clk_ready_flag_r) ? 2'b00 : 2'b10;
               end
            end
            ST_RUN: begin
               if (wdt_timeout || ext_reset_req) begin
                  state_r <= ST_WDT_RST;
               end else if (sleep_ok) begin
                  state_r <= idle_on_sleep_sel ? ST_IDLE : ST_SLEEP;
                  run_src_r <= sys_clk_select[1] ? 2'b10 : sys_clk_select;
               end
            end
            ST_IDLE, ST_SLEEP: begin
               if (ext_reset_req) begin
                  state_r <= ST_WDT_RST;
               end else if (wake_evt) begin
                  state_r <= ST_WAKE;
                  irq_wake_r <= irq_wake;
               end
            end
            ST_WAKE: begin
               if (wake_go) begin
                  state_r <= ST_RUN;
               end
            end
            ST_WDT_RST: state_r <= ST_RESET;
         endcase
      end
   end

   // Execution resumes the cycle after both the ready delay and the start-up timer delay end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_start <= 1'b0;
         irq_vector_branch <= 1'b0;
         watchdog_reset <= 1'b0;
      end else begin
         cpu_start <= wake_go;
         irq_vector_branch <= wake_go && irq_wake_r && global_irq_enable;
         watchdog_reset <= (state_r == ST_RUN) && wdt_timeout;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Clock status flags

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         primary_clk_ready_flag_r <= 1'b0;
         secondary_osc_running_flag_r <= 1'b0;
      end else if (state_r == ST_RUN && sleep_ok && !idle_on_sleep_sel) begin
         primary_clk_ready_flag_r <= 1'b0;
         secondary_osc_running_flag_r <= 1'b0;
      end else if (state_r == ST_RUN && sleep_ok && sys_clk_select != 2'b00) begin
         primary_clk_ready_flag_r <= 1'b0;
         secondary_osc_running_flag_r <= (sys_clk_select == 2'b01);
      end else if (ost_done) begin
         primary_clk_ready_flag_r <= 1'b1;
      end
   end
   // primary idle leaves the ready flag as it was

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         internal_osc_stable_flag_r <= 1'b0;
      end else if (!internal_fast_osc_req ||
                   (state_r == ST_RUN && sleep_ok && !idle_on_sleep_sel)) begin
         internal_osc_stable_flag_r <= 1'b0;
      end else if (stab_done) begin
         internal_osc_stable_flag_r <= 1'b1;
      end
   end
   // a stable flag is only cleared by the cases above

   ////////////////////////////////////////////////////////////////////////////////
   // Delay counters

   imw_delay_cnt u_ready_cnt (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(rdy_start),
      .abort(1'b0),
      .cycles(CPU_READY_CYCLES),
      .busy(rdy_busy),
      .done()
   );

   imw_delay_cnt u_stab_cnt (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(stab_start),
      .abort(!internal_fast_osc_req),
      .cycles(OSC_STAB_CYCLES),
      .busy(stab_busy),
      .done(stab_done)
   );

   imw_delay_cnt u_ost_cnt (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(ost_start),
      .abort(1'b0),
      .cycles(OST_CYCLES),
      .busy(ost_busy),
      .done(ost_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog counter

   always_ff @(posedge aclk) begin
      if (!aresetn || !wdt_enable) begin
         wdt_cnt_r <= '0;
      end else if (sleep_instr || watchdog_clear_instr || wdt_wr || wdt_timeout ||
                   (clk_loss && clk_monitor_en) ||
                   (osc_wr && run_src_r[1] &&
                    osc_ctrl_nxt[INTERNAL_FREQ_SELECT_LSB +: 3] != internal_freq_select)) begin
         wdt_cnt_r <= '0;
      end else begin
         wdt_cnt_r <= wdt_cnt_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Clock gating outputs

   always_comb begin
      cpu_clk_en = (state_r == ST_RUN);
      periph_clk_en = (state_r != ST_SLEEP) && (state_r != ST_RESET);
      periph_clk_src = run_src_r;
      primary_osc_en = (state_r == ST_RESET) || (run_src_r == 2'b00) ||
                       (state_r == ST_WAKE && ost_busy);
      secondary_osc_en = secondary_osc_enable;
      internal_osc_out_en = internal_fast_osc_req || (state_r == ST_RESET && two_speed_en);
      internal_slow_osc_en = wdt_enable || clk_monitor_en || run_src_r[1];
      if (state_r == ST_SLEEP) begin
         primary_osc_en = 1'b0;
      end
   end

endmodule

// >>> dv/imw_checker.sv
module imw_checker
   import imw_pkg::*;
#(
   parameter logic [CNT_W-1:0] CPU_READY_CYCLES = 16'h0008
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Wake sources
   input wire logic [7:0] irq_flags,
   input wire logic [7:0] irq_enables,
   // Clock control
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic [1:0] periph_clk_src,
   input wire logic primary_osc_en,
   input wire logic secondary_osc_en,
   // Core control
   input wire logic irq_vector_branch,
   input wire logic watchdog_reset,
   input wire logic cpu_start
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WMIN = int'(CPU_READY_CYCLES) + 1;
   localparam int WMAX = int'(CPU_READY_CYCLES) + 3;
   logic idle;
   logic pend;
   assign idle = !cpu_clk_en && periph_clk_en;
   assign pend = |(irq_flags & irq_enables);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   a_wake_latency: assert property (idle && $rose(pend) |-> ##[WMIN:WMAX] cpu_start)
      else $error("cpu start missing after wake");
   a_start_runs: assert property (cpu_start |=> cpu_clk_en [*2])
      else $error("cpu clock off after start");
   a_start_halted: assert property (cpu_start |-> $past(!cpu_clk_en))
      else $error("start while running");
   a_branch_start: assert property (irq_vector_branch |-> cpu_start)
      else $error("branch without start");
   a_wdt_running: assert property (watchdog_reset |-> $past(cpu_clk_en))
      else $error("watchdog reset while halted");
   a_resume_src: assert property (cpu_start && $past(periph_clk_en) |-> $stable(periph_clk_src))
      else $error("clock source changed at wake");
   a_sec_kept: assert property (periph_clk_en && periph_clk_src == 2'h1 |-> secondary_osc_en)
      else $error("secondary oscillator stopped");
   a_primary_idle_mode: assert property (idle && periph_clk_src == 2'h0 |-> primary_osc_en)
      else $error("primary stopped in primary idle");
   c_start: cover property (cpu_start);
   c_branch: cover property (irq_vector_branch);
   c_wdt: cover property (watchdog_reset);
endmodule

// >>> dv/imw_far_model.sv
module imw_far_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // From the controller
   input wire logic primary_osc_en,
   input wire logic cpu_start,
   // From the bench
   input wire logic [7:0] irq_req,
   // To the controller
   output logic primary_osc_ready,
   output logic [7:0] irq_flags
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] warm_r;
   // Primary oscillator needs a few cycles to start after enable
   always_ff @(posedge aclk) begin
      if (!aresetn || !primary_osc_en) begin
         warm_r <= 4'h0;
      end else if (warm_r != 4'hF) begin
         warm_r <= warm_r + 4'h1;
      end
   end
   assign primary_osc_ready = warm_r >= 4'h5;
   // Flags latch until the core takes the wake
   always_ff @(posedge aclk) begin
      if (!aresetn || cpu_start) begin
         irq_flags <= 8'h00;
      end else begin
         irq_flags <= irq_flags | irq_req;
      end
   end
endmodule

// >>> dv/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import imw_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, periph_clk_src;
   logic sleep_instr = 1'b0, watchdog_clear_instr = 1'b0;
   logic clk_loss = 1'b0, ext_reset_req = 1'b0;
   logic [7:0] irq_flags, irq_req = 8'h00, irq_enables = 8'h02;
   logic primary_osc_ready, cpu_clk_en, periph_clk_en, primary_osc_en, secondary_osc_en;
   logic internal_osc_out_en, internal_slow_osc_en, irq_vector_branch, watchdog_reset;
   logic cpu_start;
   logic wr_seen = 1'b0;
   int n_mismatch = 0, total_checks = 0, cyc = 0;
   imw_wake_ctrl #(.CPU_READY_CYCLES(16'h0008), .OSC_STAB_CYCLES(16'h0028),
      .OST_CYCLES(16'h000A), .WDT_PERIOD(16'h0060)) uut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .sleep_instr, .watchdog_clear_instr, .irq_flags, .irq_enables,
      .primary_osc_ready, .clk_loss, .ext_reset_req, .cpu_clk_en, .periph_clk_en,
      .periph_clk_src, .primary_osc_en, .secondary_osc_en, .internal_osc_out_en,
      .internal_slow_osc_en, .irq_vector_branch, .watchdog_reset, .cpu_start);
   imw_far_model far (.aclk, .aresetn, .primary_osc_en, .cpu_start, .irq_req,
      .primary_osc_ready, .irq_flags);
   always #12.5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (watchdog_reset === 1'b1) begin
         wr_seen <= 1'b1;
      end
      if (cyc == 10000) begin
         n_mismatch++;
         results();
      end
   end
   ////////////////////////////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw;
      bit w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         aw = aw && s_axi_awready !== 1'b1;
         w = w && s_axi_wready !== 1'b1;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end while (aw || w);
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er), "write response");
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
         input logic [1:0] er, input string s);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata & m, e, s);
      chk(32'(s_axi_rresp), 32'(er), "read response");
   endtask
   task automatic slp();
      @(posedge aclk);
      sleep_instr <= 1'b1;
      @(posedge aclk);
      sleep_instr <= 1'b0;
      repeat (3) @(posedge aclk);
      #1;
   endtask
   // Raise an interrupt request, then wait for execution to restart
   task automatic wake(input logic [7:0] irq, input logic br, input string s);
      int n;
      n = 0;
      @(posedge aclk);
      irq_req <= irq;
      @(posedge aclk);
      irq_req <= 8'h00;
      while (cpu_start !== 1'b1 && n < 400) begin
         @(posedge aclk);
         n++;
      end
      chk(32'(cpu_start), 32'h1, s);
      chk(32'(irq_vector_branch), 32'(br), "vector branch");
      repeat (2) @(posedge aclk);
      #1;
      chk(32'(cpu_clk_en), 32'h1, "cpu running after wake");
   endtask
   task automatic wait_run();
      int n;
      n = 0;
      while (cpu_clk_en !== 1'b1 && n < 500) begin
         @(posedge aclk);
         n++;
      end
      chk(32'(cpu_clk_en), 32'h1, "reset exit");
   endtask
   ////////////////////////////////////////
   task automatic t_regs();
      rdc(ADDR_STATUS, 32'hF, 32'h9, RESP_OKAY, "status after reset");
      rdc(8'h10, 32'hFFFFFFFF, 32'h0, RESP_SLVERR, "unmapped read");
      axi_wr(8'h14, 32'h1, RESP_SLVERR);
      $display("done regs");
   endtask
   task automatic t_pri();
      axi_wr(ADDR_IRQ_CTRL, 32'h80, RESP_OKAY);
      axi_wr(ADDR_OSC_CTRL, 32'h81, RESP_OKAY);
      axi_wr(ADDR_OSC_CTRL, 32'h80, RESP_OKAY);
      slp();
      chk(32'({cpu_clk_en, periph_clk_en, periph_clk_src, primary_osc_en}), 32'h9, "primary_idle_mode");
      rdc(ADDR_STATUS, 32'h1, 32'h1, RESP_OKAY, "primary ready kept");
      irq_req <= 8'h01;
      repeat (30) @(posedge aclk);
      #1;
      chk(32'(cpu_clk_en), 32'h0, "masked irq woke");
      wake(8'h02, 1'b1, "pri wake");
      rdc(ADDR_OSC_CTRL, 32'hFF, 32'h80, RESP_OKAY, "control kept");
      rdc(ADDR_STATUS, 32'h1, 32'h1, RESP_OKAY, "primary ready after wake");
      $display("done primary_idle_mode");
   endtask
   task automatic t_sec();
      axi_wr(ADDR_IRQ_CTRL, 32'h00, RESP_OKAY);
      axi_wr(ADDR_OSC_CTRL, 32'h81, RESP_OKAY);
      slp();
      chk(32'(cpu_clk_en), 32'h1, "sleep not ignored");
      axi_wr(ADDR_OSC_CTRL, 32'h85, RESP_OKAY);
      slp();
      chk(32'({periph_clk_src, primary_osc_en, secondary_osc_en}), 32'h5, "secondary_idle_mode");
      rdc(ADDR_STATUS, 32'h7, 32'h4, RESP_OKAY, "sec flags");
      wake(8'h02, 1'b0, "sec wake");
      chk(32'({periph_clk_src, secondary_osc_en}), 32'h3, "sec resume");
      $display("done secondary_idle_mode");
   endtask
   task automatic t_rc();
      axi_wr(ADDR_OSC_CTRL, 32'h1A7, RESP_OKAY);
      slp();
      chk(32'({periph_clk_src, primary_osc_en}), 32'h4, "internal_idle_mode");
      chk(32'({internal_osc_out_en, internal_slow_osc_en}), 32'h3, "rc sources");
      rdc(ADDR_STATUS, 32'h3, 32'h0, RESP_OKAY, "stable early");
      repeat (45) @(posedge aclk);
      rdc(ADDR_STATUS, 32'h2, 32'h2, RESP_OKAY, "stable late");
      wr_seen = 1'b0;
      wake(8'h00, 1'b0, "watchdog wake");
      chk(32'(wr_seen), 32'h0, "watchdog reset in idle");
      chk(32'({periph_clk_src, internal_slow_osc_en}), 32'h5, "rc resume");
      $display("done internal_idle_mode");
   endtask
   task automatic t_wdt();
      wr_seen = 1'b0;
      repeat (4) begin
         @(posedge aclk);
         watchdog_clear_instr <= 1'b1;
         @(posedge aclk);
         watchdog_clear_instr <= 1'b0;
         repeat (40) @(posedge aclk);
      end
      chk(32'(wr_seen), 32'h0, "reset despite clear");
      repeat (200) @(posedge aclk);
      chk(32'(wr_seen), 32'h1, "no watchdog reset");
      wait_run();
      $display("done watchdog");
   endtask
   task automatic t_sleep();
      axi_wr(ADDR_OSC_CTRL, 32'h00, RESP_OKAY);
      slp();
      chk(32'({cpu_clk_en, periph_clk_en}), 32'h0, "full sleep");
      rdc(ADDR_STATUS, 32'h7, 32'h0, RESP_OKAY, "sleep flags");
      wake(8'h02, 1'b0, "sleep wake");
      $display("done sleep");
   endtask
   task automatic t_rst();
      axi_wr(ADDR_OSC_CTRL, 32'h80, RESP_OKAY);
      slp();
      @(posedge aclk);
      ext_reset_req <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_reset_req <= 1'b0;
      #1;
      chk(32'(cpu_clk_en), 32'h0, "held in reset");
      wait_run();
      rdc(ADDR_STATUS, 32'h1, 32'h1, RESP_OKAY, "primary ready after reset");
      $display("done reset exit");
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      wait_run();
      t_regs();
      t_pri();
      t_sec();
      t_rc();
      t_wdt();
      t_sleep();
      t_rst();
      results();
   end
endmodule
bind imw_wake_ctrl imw_checker #(.CPU_READY_CYCLES(CPU_READY_CYCLES)) chk_i (.aclk, .aresetn,
   .irq_flags, .irq_enables, .cpu_clk_en, .periph_clk_en, .periph_clk_src, .primary_osc_en,
   .secondary_osc_en, .irq_vector_branch, .watchdog_reset, .cpu_start);
